// ===== bcirq_top.v
// Interrupt flags, enables, clears and the fourteen channel register sets
// Overview of operation
// (RULE1) Enable register bits 4..0 gate event interrupts
// (RULE2) Reset clears event enables, sets bit 7
// (RULE3) Status register shows pending event flags
// (RULE4) Clear register write-only, ones clear flags
// (RULE5) Clear bits 7,4,3,2,1,0 map to flags
// (RULE6) Software writes zero to clear bits 5,6
// (RULE7) Fourteen channel sets of eight bytes each
// (RULE8) Channel n based at 0x10 plus 8n
// (RULE9) Resets leave channel registers untouched
// (RULE10) Software initialises channels before leaving idle
// (RULE11) Offsets 0,1 hold tag and command
// (RULE12) Offsets 6,7 hold mask; 4,5 empty
// (RULE13) Offsets 2,3 hold pointer, length, status
// (RULE14) Mask bit one enables identifier bit compare
// (RULE15) Pointer is offset from message RAM 0x80
// (RULE16) Software clears status bits to request transfer
// (RULE17) Interrupt low while enabled flag pending
`timescale 1ns/1ps
`include "bcirq_defs.vh"
module bcirq_top (
  // Clock and reset
  input  wire         MCLK_I,
  input  wire         ARST_N_I,
  // General reset command from the command register
  input  wire         GEN_RESET_I,
  // Register port from the serial host interface
  input  wire         REG_WR_I,
  input  wire         REG_RD_I,
  input  wire [7:0]   REG_ADDR_I,
  input  wire [7:0]   REG_WDATA_I,
  output reg  [7:0]   REG_RDATA_O,
  // Event pulses from the frame engine
  input  wire         EVT_TX_FAULT_I,
  input  wire         EVT_TX_DONE_I,
  input  wire         EVT_RX_FAULT_I,
  input  wire         EVT_RX_ACKED_I,
  input  wire         EVT_RX_UNACKED_I,
  // Channel status set pulses: index 3n+2 error, 3n+1 transmitted, 3n received
  input  wire [41:0]  CHAN_STS_SET_I,
  // Channel field view, channel n at bits [12n+11:12n] etc.
  output wire [167:0] CHAN_TAG_O,
  output wire [167:0] CHAN_MASK_O,
  output wire [55:0]  CHAN_CMD_O,
  output wire [111:0] CHAN_MSG_ADDR_O,
  output wire [69:0]  CHAN_LEN_O,
  output wire [41:0]  CHAN_STATUS_O,
  output wire [13:0]  CHAN_ACK_DIS_O,
  // Interrupt pin, open drain, active low
  output wire         IRQ_N_O,
  output wire         IRQ_OE_O
);
  // Interrupt state
  reg  [7:0]   flags_reg;
  reg  [7:0]   enable_reg;
  reg  [7:0]   flags_next;
  reg          gen_reset_d_reg;
  wire [7:0]   evt_set;
  wire [7:0]   clr_bits;
  wire         clr_wr;
  wire         en_wr;
  wire         irq_any;
  // Channel window decode and read path
  wire         in_chan;
  wire [7:0]   chan_rel;
  wire [3:0]   chan_idx;
  wire [111:0] chan_rd;
  reg  [7:0]   chan_rd_sel;
  // Per-flag clear strobes
  wire         reset_seen_clear;
  wire         tx_fault_clear;
  wire         tx_done_clear;
  wire         rx_fault_clear;
  wire         rx_acked_clear;
  wire         rx_unacked_clear;
  // Per-source flag and enable views
  wire         reset_seen_flag;
  wire         tx_fault_flag;
  wire         tx_done_flag;
  wire         rx_fault_flag;
  wire         rx_acked_done_flag;
  wire         rx_unacked_done_flag;
  wire         reset_seen_irq_en;
  wire         tx_fault_irq_en;
  wire         tx_done_irq_en;
  wire         rx_fault_irq_en;
  wire         rx_acked_irq_en;
  wire         rx_unacked_irq_en;

  // Decode channel window (see (RULE8))
  assign in_chan  = (REG_ADDR_I >= `BCIRQ_CHAN_BASE) && (REG_ADDR_I <= `BCIRQ_CHAN_LAST);
  assign chan_rel = REG_ADDR_I - `BCIRQ_CHAN_BASE;
  assign chan_idx = chan_rel[6:3]; // see (RULE8)

  // Event set vector; reset-seen flag set on the release of a general reset
  assign evt_set = {gen_reset_d_reg & ~GEN_RESET_I, 2'b00, EVT_TX_FAULT_I, EVT_TX_DONE_I,
                    EVT_RX_FAULT_I, EVT_RX_ACKED_I, EVT_RX_UNACKED_I};
  // Host strobes of the two writable interrupt registers
  assign clr_wr = REG_WR_I && (REG_ADDR_I == `BCIRQ_OFS_CLEAR); // see (RULE4)
  assign en_wr  = REG_WR_I && (REG_ADDR_I == `BCIRQ_OFS_ENABLE); // see (RULE1)

  // One clear strobe per flag; a zero bit leaves its flag alone
  assign reset_seen_clear = clr_wr & REG_WDATA_I[`BCIRQ_BIT_RESET_SEEN]; // see (RULE5)
  assign tx_fault_clear   = clr_wr & REG_WDATA_I[`BCIRQ_BIT_TX_FAULT]; // see (RULE5)
  assign tx_done_clear    = clr_wr & REG_WDATA_I[`BCIRQ_BIT_TX_DONE]; // see (RULE5)
  assign rx_fault_clear   = clr_wr & REG_WDATA_I[`BCIRQ_BIT_RX_FAULT]; // see (RULE5)
  assign rx_acked_clear   = clr_wr & REG_WDATA_I[`BCIRQ_BIT_RX_ACKED]; // see (RULE5)
  assign rx_unacked_clear = clr_wr & REG_WDATA_I[`BCIRQ_BIT_RX_UNACKED]; // see (RULE5)
  // Reserved clear bits 5 and 6 drive nothing, so a stray one is harmless (see (RULE6))
  assign clr_bits = {reset_seen_clear, 2'b00, tx_fault_clear, tx_done_clear,
                     rx_fault_clear, rx_acked_clear, rx_unacked_clear};

  // Ones clear, zeros keep; a set in the same cycle wins
  always @* begin
    flags_next = (flags_reg & ~clr_bits) | evt_set; // see (RULE4)
  end

  // Flags and enables; either reset source sets the reset-seen flag
  always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      flags_reg       <= `BCIRQ_ENABLE_RESET;
      enable_reg      <= `BCIRQ_ENABLE_RESET; // see (RULE2)
      gen_reset_d_reg <= 1'b0;
    end else begin
      gen_reset_d_reg <= GEN_RESET_I;
      if (GEN_RESET_I) begin
        flags_reg  <= 8'h00;
        enable_reg <= `BCIRQ_ENABLE_RESET; // see (RULE2)
      end else begin
        flags_reg <= flags_next; // see (RULE3)
        if (en_wr)
          enable_reg <= (REG_WDATA_I & `BCIRQ_FLAG_MASK); // see (RULE1)
      end
    end
  end

  // Channel sets, one instance each (see (RULE7))
  genvar g;
  generate
    for (g = 0; g < `BCIRQ_CHAN_COUNT; g = g + 1) begin : g_chan
      bcirq_chan_set u_set (
        .clk_i                (MCLK_I),
        .wr_en_i              (REG_WR_I && in_chan && chan_idx == g),
        .wr_slot_i            (chan_rel[2:0]),
        .wr_data_i            (REG_WDATA_I),
        .sts_set_i            (CHAN_STS_SET_I[3*g+2:3*g]),
        .rd_slot_i            (chan_rel[2:0]),
        .rd_data_o            (chan_rd[8*g+7:8*g]),
        .ident_tag_o          (CHAN_TAG_O[12*g+11:12*g]),
        .cmd_o                (CHAN_CMD_O[4*g+3:4*g]),
        .ident_compare_mask_o (CHAN_MASK_O[12*g+11:12*g]),
        .msg_addr_o           (CHAN_MSG_ADDR_O[8*g+7:8*g]),
        .ack_reply_disable_o  (CHAN_ACK_DIS_O[g]),
        .msg_len_o            (CHAN_LEN_O[5*g+4:5*g]),
        .chan_status_o        (CHAN_STATUS_O[3*g+2:3*g])
      );
    end
  endgenerate

  // Channel read select; indices 14 and 15 lie outside the window
  // and read zero, so no slice past the end of the read bus is taken
  always @* begin
    case (chan_idx)
      4'h0:    chan_rd_sel = chan_rd[7:0];
      4'h1:    chan_rd_sel = chan_rd[15:8];
      4'h2:    chan_rd_sel = chan_rd[23:16];
      4'h3:    chan_rd_sel = chan_rd[31:24];
      4'h4:    chan_rd_sel = chan_rd[39:32];
      4'h5:    chan_rd_sel = chan_rd[47:40];
      4'h6:    chan_rd_sel = chan_rd[55:48];
      4'h7:    chan_rd_sel = chan_rd[63:56];
      4'h8:    chan_rd_sel = chan_rd[71:64];
      4'h9:    chan_rd_sel = chan_rd[79:72];
      4'hA:    chan_rd_sel = chan_rd[87:80];
      4'hB:    chan_rd_sel = chan_rd[95:88];
      4'hC:    chan_rd_sel = chan_rd[103:96];
      4'hD:    chan_rd_sel = chan_rd[111:104]; // see (RULE7)
      default: chan_rd_sel = 8'h00;
    endcase
  end

  // Registered read data; clear register and unmapped space read zero
  always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      if (REG_ADDR_I == `BCIRQ_OFS_STATUS)
        REG_RDATA_O <= flags_reg; // see (RULE3)
      else if (REG_ADDR_I == `BCIRQ_OFS_ENABLE)
        REG_RDATA_O <= enable_reg | 8'h80;
      else if (in_chan)
        REG_RDATA_O <= chan_rd_sel;
      else
        REG_RDATA_O <= 8'h00; // see (RULE4)
    end
  end

  // Named views of the pending flags
  assign reset_seen_flag      = flags_reg[`BCIRQ_BIT_RESET_SEEN];
  assign tx_fault_flag        = flags_reg[`BCIRQ_BIT_TX_FAULT];
  assign tx_done_flag         = flags_reg[`BCIRQ_BIT_TX_DONE]; // see (RULE3)
  assign rx_fault_flag        = flags_reg[`BCIRQ_BIT_RX_FAULT]; // see (RULE3)
  assign rx_acked_done_flag   = flags_reg[`BCIRQ_BIT_RX_ACKED]; // see (RULE3)
  assign rx_unacked_done_flag = flags_reg[`BCIRQ_BIT_RX_UNACKED]; // see (RULE3)

  // Named views of the enables; bit 7 gates the reset-seen source
  assign reset_seen_irq_en = enable_reg[`BCIRQ_BIT_RESET_SEEN]; // see (RULE2)
  assign tx_fault_irq_en   = enable_reg[`BCIRQ_BIT_TX_FAULT]; // see (RULE1)
  assign tx_done_irq_en    = enable_reg[`BCIRQ_BIT_TX_DONE]; // see (RULE1)
  assign rx_fault_irq_en   = enable_reg[`BCIRQ_BIT_RX_FAULT]; // see (RULE1)
  assign rx_acked_irq_en   = enable_reg[`BCIRQ_BIT_RX_ACKED]; // see (RULE1)
  assign rx_unacked_irq_en = enable_reg[`BCIRQ_BIT_RX_UNACKED]; // see (RULE1)

  // Open-drain interrupt: drive low only while an enabled flag is pending
  assign irq_any  = (reset_seen_flag & reset_seen_irq_en) |
                    (tx_fault_flag & tx_fault_irq_en) |
                    (tx_done_flag & tx_done_irq_en) |
                    (rx_fault_flag & rx_fault_irq_en) |
                    (rx_acked_done_flag & rx_acked_irq_en) |
                    (rx_unacked_done_flag & rx_unacked_irq_en); // see (RULE17)
  assign IRQ_N_O  = 1'b0;
  assign IRQ_OE_O = irq_any; // see (RULE17)
endmodule // bcirq_top

// ===== bcirq_defs.vh
// Register offsets, field positions and reset values of the interrupt and channel block
`ifndef BCIRQ_DEFS_VH
`define BCIRQ_DEFS_VH
`define BCIRQ_OFS_STATUS      8'h09
`define BCIRQ_OFS_ENABLE      8'h0A
`define BCIRQ_OFS_CLEAR       8'h0B
`define BCIRQ_CHAN_BASE       8'h10
`define BCIRQ_CHAN_LAST       8'h7F
`define BCIRQ_CHAN_COUNT      14
`define BCIRQ_SLOT_TAG_HI     3'h0
`define BCIRQ_SLOT_TAG_LO     3'h1
`define BCIRQ_SLOT_PTR        3'h2
`define BCIRQ_SLOT_LEN        3'h3
`define BCIRQ_SLOT_MASK_HI    3'h6
`define BCIRQ_SLOT_MASK_LO    3'h7
`define BCIRQ_MSG_RAM_BASE    8'h80
`define BCIRQ_BIT_RESET_SEEN  7
`define BCIRQ_BIT_TX_FAULT    4
`define BCIRQ_BIT_TX_DONE     3
`define BCIRQ_BIT_RX_FAULT    2
`define BCIRQ_BIT_RX_ACKED    1
`define BCIRQ_BIT_RX_UNACKED  0
`define BCIRQ_FLAG_MASK       8'h9F
`define BCIRQ_ENABLE_RESET    8'h80
`endif

// ===== bcirq_chan_set.v
// One channel register set: tag, command, pointer, length/status and mask
`timescale 1ns/1ps
`include "bcirq_defs.vh"
module bcirq_chan_set (
  // Clock
  input  wire       clk_i,
  // Host write
  input  wire       wr_en_i,
  input  wire [2:0] wr_slot_i,
  input  wire [7:0] wr_data_i,
  // Frame engine status set
  input  wire [2:0] sts_set_i,
  // Read
  input  wire [2:0] rd_slot_i,
  output reg  [7:0] rd_data_o,
  // Decoded fields
  output wire [11:0] ident_tag_o,
  output wire [3:0]  cmd_o,
  output wire [11:0] ident_compare_mask_o,
  output wire [7:0]  msg_addr_o,
  output wire        ack_reply_disable_o,
  output wire [4:0]  msg_len_o,
  output wire [2:0]  chan_status_o
);
  // No reset here: contents survive both resets (see RULE9)
  reg [7:0] tag_hi_reg;
  reg [7:0] tag_lo_reg;
  reg [7:0] ptr_reg;
  reg [7:0] len_reg;
  reg [7:0] mask_hi_reg;
  reg [3:0] mask_lo_reg;
  // Base plus offset kept one bit wider so the cut below is deliberate
  wire [8:0] msg_sum;

  // Host writes; engine sets of status bits win over a host write
  always @(posedge clk_i) begin
    if (wr_en_i && wr_slot_i == `BCIRQ_SLOT_TAG_HI) tag_hi_reg <= wr_data_i; // see (RULE11)
    if (wr_en_i && wr_slot_i == `BCIRQ_SLOT_TAG_LO) tag_lo_reg <= wr_data_i; // see (RULE11)
    if (wr_en_i && wr_slot_i == `BCIRQ_SLOT_PTR) ptr_reg <= wr_data_i; // see (RULE13)
    if (wr_en_i && wr_slot_i == `BCIRQ_SLOT_LEN)
      len_reg <= {wr_data_i[7:3], wr_data_i[2:0] | sts_set_i}; // see (RULE13)
    else
      len_reg <= {len_reg[7:3], len_reg[2:0] | sts_set_i};
    if (wr_en_i && wr_slot_i == `BCIRQ_SLOT_MASK_HI) mask_hi_reg <= wr_data_i; // see (RULE12)
    if (wr_en_i && wr_slot_i == `BCIRQ_SLOT_MASK_LO) mask_lo_reg <= wr_data_i[7:4]; // see (RULE12)
  end

  // Read mux; slots 4 and 5 hold nothing and read zero
  always @* begin
    case (rd_slot_i)
      `BCIRQ_SLOT_TAG_HI:  rd_data_o = tag_hi_reg;
      `BCIRQ_SLOT_TAG_LO:  rd_data_o = tag_lo_reg;
      `BCIRQ_SLOT_PTR:     rd_data_o = ptr_reg;
      `BCIRQ_SLOT_LEN:     rd_data_o = len_reg;
      `BCIRQ_SLOT_MASK_HI: rd_data_o = mask_hi_reg;
      `BCIRQ_SLOT_MASK_LO: rd_data_o = {mask_lo_reg, 4'h0};
      default:             rd_data_o = 8'h00; // see (RULE12)
    endcase
  end

  // Field view for the frame engine
  assign ident_tag_o          = {tag_hi_reg, tag_lo_reg[7:4]};
  assign cmd_o                = tag_lo_reg[3:0];
  assign ident_compare_mask_o = {mask_hi_reg, mask_lo_reg}; // see (RULE14)
  assign ack_reply_disable_o  = ptr_reg[7];
  assign msg_sum              = {1'b0, `BCIRQ_MSG_RAM_BASE} + {2'b00, ptr_reg[6:0]}; // see (RULE15)
  assign msg_addr_o           = msg_sum[7:0]; // see (RULE15)
  assign msg_len_o            = len_reg[7:3];
  assign chan_status_o        = len_reg[2:0];
endmodule // bcirq_chan_set

// ===== bcirq_props.sv
// Port-level checks of the interrupt and channel register block
`timescale 1ns/1ps
module bcirq_props (
  // Clock, resets and host port
  input wire         MCLK_I, ARST_N_I, GEN_RESET_I, REG_WR_I, REG_RD_I,
  input wire [7:0]   REG_ADDR_I, REG_WDATA_I, REG_RDATA_O,
  // Events, channel view and interrupt pin
  input wire         EVT_TX_FAULT_I, EVT_TX_DONE_I, IRQ_N_O, IRQ_OE_O,
  input wire [167:0] CHAN_TAG_O,
  input wire [111:0] CHAN_MSG_ADDR_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  // Register reads answer one edge after the strobe
  en_bit_a: assert property (REG_RD_I && REG_ADDR_I == 8'h0A |=> REG_RDATA_O[7:5] == 3'h4)
    else $error("enable readback bad");
  clear_read_a: assert property (REG_RD_I && REG_ADDR_I == 8'h0B |=> REG_RDATA_O == 8'h00)
    else $error("clear register not zero");
  clear_flag_a: assert property (REG_WR_I && REG_ADDR_I == 8'h0B && REG_WDATA_I[3] &&
    !EVT_TX_DONE_I ##1 !EVT_TX_DONE_I ##1 REG_RD_I && REG_ADDR_I == 8'h09 |=> !REG_RDATA_O[3])
    else $error("tx done flag not cleared");
  event_flag_a: assert property (EVT_TX_FAULT_I ##1 REG_RD_I && REG_ADDR_I == 8'h09
    |=> REG_RDATA_O[4]) else $error("tx fault flag missing");
  // Reset-seen source is enabled and pending after a pin reset
  reset_irq_a: assert property ($rose(ARST_N_I) |-> IRQ_OE_O)
    else $error("no interrupt after reset");
  gen_irq_a: assert property (GEN_RESET_I [*2] |-> !IRQ_OE_O)
    else $error("interrupt during general reset");
  irq_pin_a: assert property (IRQ_N_O == 1'b0)
    else $error("open drain level not low");
  irq_off_a: assert property (REG_WR_I && REG_ADDR_I == 8'h0A && REG_WDATA_I == 8'h00 &&
    !GEN_RESET_I |=> !IRQ_OE_O) else $error("interrupt with all sources disabled");
  chan_tag_a: assert property (REG_WR_I && REG_ADDR_I == 8'h10
    |=> CHAN_TAG_O[11:4] == $past(REG_WDATA_I)) else $error("tag high not stored");
  chan_ptr_a: assert property (REG_WR_I && REG_ADDR_I == 8'h12
    |=> CHAN_MSG_ADDR_O[7:0] == {1'b1, $past(REG_WDATA_I[6:0])}) else $error("pointer bad");
endmodule // bcirq_props
bind bcirq_top bcirq_props i_bcirq_props (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I),
  .GEN_RESET_I(GEN_RESET_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .EVT_TX_FAULT_I(EVT_TX_FAULT_I), .EVT_TX_DONE_I(EVT_TX_DONE_I), .IRQ_N_O(IRQ_N_O),
  .IRQ_OE_O(IRQ_OE_O), .CHAN_TAG_O(CHAN_TAG_O), .CHAN_MSG_ADDR_O(CHAN_MSG_ADDR_O));

// ===== bcirq_host.sv
// Host model: byte writes and reads on the register port
`timescale 1ns/1ps
module bcirq_host (
  input  wire       clk_i,
  input  wire [7:0] rdata_i,
  output reg        wr_o = 1'b0,
  output reg        rd_o = 1'b0,
  output reg  [7:0] addr_o = 8'h00,
  output reg  [7:0] wdata_o = 8'h00
);
  // Write held for one edge; reserved clear bits always sent as zero
  task wr(input [7:0] a, input [7:0] d);
    begin
      addr_o = a;
      wdata_o = (a == 8'h0B) ? (d & 8'h9F) : d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      wdata_o = ~wdata_o; // Released data must not look valid
      @(negedge clk_i); // Idle edge so a strobe never toggles twice in one step
    end
  endtask
  // Read data is taken one edge after the strobe
  task rd(input [7:0] a, output [7:0] d);
    begin
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      d = rdata_i;
      @(negedge clk_i); // Idle edge; read data holds until the next read
    end
  endtask
endmodule // bcirq_host

// ===== bcirq_top_bench.sv
// Self-checking bench of the interrupt and channel register block
`timescale 1ns/1ps
module bcirq_top_bench;
  reg         clk = 1'b0;
  reg         arst_n;
  reg         gres = 1'b0;
  reg  [4:0]  ev = 5'h00;
  reg  [41:0] sts = 42'h0;
  reg  [7:0]  d;
  wire [7:0]  rdata, addr, wdata;
  wire        wr, rd, irq_oe;
  wire [167:0] tag_v, mask_v;
  wire [111:0] maddr_v;
  wire [69:0]  len_v;
  wire [55:0]  cmd_v;
  wire [41:0]  stat_v;
  wire [13:0]  ackd_v;
  integer     n_mismatch = 0, comparisons = 0, fl, en, b, c, o, i;
  integer     mem [0:127];
  integer     offs [0:5] = '{0, 1, 2, 3, 6, 7};
  always #50 clk = ~clk;
  bcirq_host i_bcirq_host (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  bcirq_top i_bcirq_top (.MCLK_I(clk), .ARST_N_I(arst_n), .GEN_RESET_I(gres),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .EVT_TX_FAULT_I(ev[4]), .EVT_TX_DONE_I(ev[3]),
    .EVT_RX_FAULT_I(ev[2]), .EVT_RX_ACKED_I(ev[1]), .EVT_RX_UNACKED_I(ev[0]),
    .CHAN_STS_SET_I(sts), .CHAN_TAG_O(tag_v), .CHAN_MASK_O(mask_v), .CHAN_CMD_O(cmd_v),
    .CHAN_MSG_ADDR_O(maddr_v), .CHAN_LEN_O(len_v), .CHAN_STATUS_O(stat_v),
    .CHAN_ACK_DIS_O(ackd_v),
    .IRQ_N_O(), .IRQ_OE_O(irq_oe));
  // Compare, count and report
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rchk(input string nm, input [7:0] a, input [7:0] e);
    begin
      i_bcirq_host.rd(a, d);
      chk(nm, e, d);
    end
  endtask
  // Channel readback; low nibble of the mask low byte is unused
  task chan_cmp;
    begin
      for (i = 0; i < 84; i = i + 1) begin
        o = offs[i % 6] + (i / 6) * 8;
        c = (i % 6 == 5) ? 8'hF0 : 8'hFF;
        i_bcirq_host.rd(8'(16 + o), d);
        chk("chan", mem[o] & c, d & c);
      end
      // Field view of every channel against the byte model
      for (i = 0; i < 14; i = i + 1) begin
        o = i * 8;
        chk("tag", {mem[o][7:0], mem[o + 1][7:4]}, tag_v[12 * i +: 12]);
        chk("cmd", mem[o + 1][3:0], cmd_v[4 * i +: 4]);
        chk("mask", {mem[o + 6][7:0], mem[o + 7][7:4]}, mask_v[12 * i +: 12]);
        chk("msgaddr", 8'h80 + mem[o + 2][6:0], maddr_v[8 * i +: 8]);
        chk("ackdis", mem[o + 2][7], ackd_v[i]);
        chk("len", mem[o + 3][7:3], len_v[5 * i +: 5]);
        chk("chsts", mem[o + 3][2:0], stat_v[3 * i +: 3]);
      end
    end
  endtask
  task hard_reset;
    begin
      arst_n = 1'b0;
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      fl = 8'h80;
      en = 8'h80;
    end
  endtask
  task complete_run;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Watchdog, far beyond the normal run length
  initial begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    void'($urandom(76));
    hard_reset;
    rchk("enable", 8'h0A, en);
    for (b = 0; b < 6; b = b + 1) begin
      c = $urandom & 8'hFF;
      i_bcirq_host.wr(8'h0A, c[7:0]);
      en = c & 8'h9F;
      rchk("enable", 8'h0A, en | 8'h80);
      ev[b % 5] = 1'b1;
      @(negedge clk);
      ev[b % 5] = 1'b0;
      fl = fl | (1 << (b % 5));
      rchk("status", 8'h09, fl);
      chk("irq", (fl & en) != 0, {7'h0, irq_oe});
      c = (1 << (b % 5)) | ($urandom & 8'h9F);
      i_bcirq_host.wr(8'h0B, c[7:0]);
      fl = fl & ~c;
      rchk("status", 8'h09, fl);
      rchk("clear", 8'h0B, 8'h00);
      chk("irq", (fl & en) != 0, {7'h0, irq_oe});
    end
    i_bcirq_host.wr(8'h0A, 8'h00);
    en = 8'h00;
    chk("irq", (fl & en) != 0, {7'h0, irq_oe});
    i_bcirq_host.wr(8'h09, 8'hFF);
    rchk("status", 8'h09, fl);
    // Every channel written before use, status bits 1 and 0 written as zero, bit 2 random
    for (i = 0; i < 84; i = i + 1) begin
      o = offs[i % 6] + (i / 6) * 8;
      mem[o] = $urandom & 8'hFC;
      i_bcirq_host.wr(8'(16 + o), mem[o][7:0]);
    end
    chan_cmp;
    sts = 42'({$urandom, $urandom});
    @(negedge clk);
    for (i = 0; i < 14; i = i + 1)
      mem[i * 8 + 3] = mem[i * 8 + 3] | ((sts >> (3 * i)) & 7);
    sts = 42'h0;
    gres = 1'b1;
    repeat (2) @(negedge clk);
    gres = 1'b0;
    repeat (3) @(negedge clk);
    fl = 8'h80;
    en = 8'h80;
    rchk("status", 8'h09, fl);
    rchk("enable", 8'h0A, en);
    chk("irq", (fl & en) != 0, {7'h0, irq_oe});
    chan_cmp;
    hard_reset;
    rchk("status", 8'h09, fl);
    chk("irq", (fl & en) != 0, {7'h0, irq_oe});
    chan_cmp;
    complete_run;
  end
endmodule // bcirq_top_bench
